// *** src/bmsel_pkg.sv ***
package bmsel_pkg;

	localparam int unsigned STRAP_W = 3;
	localparam int unsigned COUNT_W = 32;

	localparam logic [STRAP_W-1:0] STRAP_SERIAL_LOAD = 3'h4;
	localparam logic [STRAP_W-1:0] STRAP_TWO_PIN     = 3'h1;
	localparam logic [STRAP_W-1:0] STRAP_FOUR_PIN    = 3'h0;
	localparam logic [STRAP_W-1:0] STRAP_BREAK       = 3'h2;
	localparam logic [STRAP_W-1:0] STRAP_RESTORE     = 3'h3;
	localparam logic [STRAP_W-1:0] STRAP_PULL_ALL    = 3'h7;
	localparam logic [STRAP_W-1:0] STRAP_RESET_VAL   = 3'h0;

	localparam longint CLOCK_HZ          = 64'd125000000;
	localparam longint US_PER_S          = 64'd1000000;
	localparam longint RESTORE_TYPICAL_S = 64'd8;
	localparam longint RESTORE_MARGIN    = 64'd3;
	localparam longint BREAK_MIN_US      = 64'd100;
	localparam longint BREAK_WATCH_US    = 64'd1000;

	localparam logic [COUNT_W-1:0] RESTORE_TIMEOUT_CYC =
		32'(RESTORE_TYPICAL_S * RESTORE_MARGIN * CLOCK_HZ);
	localparam logic [COUNT_W-1:0] BREAK_MIN_CYC =
		32'((BREAK_MIN_US * CLOCK_HZ + US_PER_S - 64'd1) / US_PER_S);
	localparam logic [COUNT_W-1:0] BREAK_WATCH_CYC =
		32'((BREAK_WATCH_US * CLOCK_HZ) / US_PER_S);
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 32'h0;
	localparam logic [COUNT_W-1:0] COUNT_ONE  = 32'h1;

	typedef enum logic [2:0] {
		MODE_NONE        = 3'h0,
		MODE_SERIAL_LOAD = 3'h1,
		MODE_TWO_PIN     = 3'h2,
		MODE_FOUR_PIN    = 3'h3,
		MODE_BREAK_WATCH = 3'h4,
		MODE_RESTORE     = 3'h5,
		MODE_RESERVED    = 3'h6
	} bmsel_mode_type;

	typedef enum logic [1:0] {
		DBG_OFF   = 2'h0,
		DBG_JTAG4 = 2'h1,
		DBG_SWD2  = 2'h2
	} bmsel_debug_type;

	typedef enum logic [1:0] {
		UART0_OFF    = 2'h0,
		UART0_LOADER = 2'h1,
		UART0_APP    = 2'h2
	} bmsel_uart_type;

	typedef enum logic [1:0] {
		RESTORE_NONE         = 2'h0,
		RESTORE_PARAMS       = 2'h1,
		RESTORE_IMAGE_PARAMS = 2'h2
	} bmsel_kind_type;

	typedef enum logic [2:0] {
		P_WAIT     = 3'b000,
		P_DECIDE   = 3'b001,
		P_WATCH    = 3'b011,
		P_LOAD     = 3'b010,
		P_RUN      = 3'b110,
		P_RESTORE  = 3'b111,
		P_RESERVED = 3'b101
	} bmsel_phase_type;

	typedef struct packed {
		bmsel_mode_type  mode;
		bmsel_debug_type debug;
		bmsel_uart_type  uart;
	} bmsel_cfg_type;

	typedef struct packed {
		logic           start;
		logic           mark_set;
		logic           mark_clr;
		logic           overdue;
		bmsel_kind_type kind;
	} bmsel_restore_type;

	typedef struct packed {
		bmsel_phase_type   phase;
		logic [STRAP_W-1:0] strap;
		logic              ext_prev;
		logic              core_run;
		bmsel_cfg_type     cfg;
		bmsel_restore_type rst;
		logic [COUNT_W-1:0] count;
		logic [COUNT_W-1:0] brk_count;
	} bmsel_state_type;

endpackage

// *** src/bmsel_sync.sv ***
`timescale 1ns/1ps
module bmsel_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         CLOCK,
	input  wire logic         RESETN,
	input  wire logic [W-1:0] ASYNC_IN,
	output logic      [W-1:0] SYNC_OUT
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// Only the second stage is visible outside
	always_ff @(posedge CLOCK)
	begin
		if (!RESETN)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= ASYNC_IN;
			sync_q <= meta_q;
		end
	end

	assign SYNC_OUT = sync_q;
endmodule // bmsel_sync

// *** src/bmsel_top.sv ***
`timescale 1ns/1ps
module bmsel_top #(
	parameter logic [31:0] RESTORE_TIMEOUT_CYCLES = bmsel_pkg::RESTORE_TIMEOUT_CYC,
	parameter logic [31:0] BREAK_MIN_CYCLES       = bmsel_pkg::BREAK_MIN_CYC,
	parameter logic [31:0] BREAK_WATCH_CYCLES     = bmsel_pkg::BREAK_WATCH_CYC
) (
	input  wire logic                   CLOCK,
	input  wire logic                   RESETN,
	input  wire logic [2:0]             BOOT_STRAP_LINES,
	input  wire logic                   EXT_RESET_IN_N,
	input  wire logic                   UART_RX,
	input  wire logic                   NV_RESTORE_PENDING,
	input  wire bmsel_pkg::bmsel_kind_type RESTORE_KIND,
	input  wire logic                   RESTORE_DONE,
	input  wire logic                   HOST_FLASH_REQ,
	input  wire logic                   HOST_FLASH_IN_FACTORY,
	output logic                        HOST_FLASH_GRANT,
	output bmsel_pkg::bmsel_cfg_type    BOOT_CFG,
	output bmsel_pkg::bmsel_restore_type RESTORE_CTL,
	output logic [2:0]                  STRAP_LATCHED,
	output logic [2:0]                  STRAP_PULLDOWN_EN,
	output logic                        CORE_RUN
);
	import bmsel_pkg::*;

	bmsel_state_type    q;
	bmsel_state_type    d;
	logic [STRAP_W-1:0] strap_s;
	logic               ext_s;
	logic               rx_s;
	logic               ext_rise;
	logic               break_seen;
	logic               watch_over;

	bmsel_sync #(
		.W       (STRAP_W),
		.RST_VAL (STRAP_RESET_VAL)
	) u_strap_sync (
		.CLOCK    (CLOCK),
		.RESETN   (RESETN),
		.ASYNC_IN (BOOT_STRAP_LINES),
		.SYNC_OUT (strap_s)
	);

	// Reset value low keeps the core held until the pin is seen high
	bmsel_sync #(
		.W       (1),
		.RST_VAL (1'b0)
	) u_ext_sync (
		.CLOCK    (CLOCK),
		.RESETN   (RESETN),
		.ASYNC_IN (EXT_RESET_IN_N),
		.SYNC_OUT (ext_s)
	);

	// Idle-high reset value so a fresh boot does not fake a break
	bmsel_sync #(
		.W       (1),
		.RST_VAL (1'b1)
	) u_rx_sync (
		.CLOCK    (CLOCK),
		.RESETN   (RESETN),
		.ASYNC_IN (UART_RX),
		.SYNC_OUT (rx_s)
	);

	assign ext_rise   = ext_s && !q.ext_prev;
	assign break_seen = !rx_s && (q.brk_count >= BREAK_MIN_CYCLES - COUNT_ONE);
	assign watch_over = q.count >= BREAK_WATCH_CYCLES - COUNT_ONE;

	function automatic bmsel_cfg_type cfg_of(input bmsel_mode_type m);
		bmsel_cfg_type c;
		c.mode = m;
		case (m)
			MODE_SERIAL_LOAD:
			begin
				c.debug = DBG_JTAG4;
				c.uart  = UART0_LOADER;
			end
			MODE_TWO_PIN:
			begin
				c.debug = DBG_SWD2;
				c.uart  = UART0_APP;
			end
			MODE_FOUR_PIN:
			begin
				c.debug = DBG_JTAG4;
				c.uart  = UART0_APP;
			end
			MODE_BREAK_WATCH:
			begin
				c.debug = DBG_JTAG4;
				c.uart  = UART0_LOADER;
			end
			default:
			begin
				c.debug = DBG_OFF;
				c.uart  = UART0_OFF;
			end
		endcase
		return c;
	endfunction

	always_comb
	begin
		d              = q;
		d.ext_prev     = ext_s;
		d.rst.start    = 1'b0;
		d.rst.mark_clr = 1'b0;
		case (q.phase)
			P_WAIT:
			begin
				// Follow the straps while reset is held; the last value wins
				d.strap = strap_s;
				if (ext_rise)
				begin
					d.phase = P_DECIDE;
				end
			end
			P_DECIDE:
			begin
				d.count     = COUNT_ZERO;
				d.brk_count = COUNT_ZERO;
				if (NV_RESTORE_PENDING)
				begin
					// Interrupted restore goes on before anything else
					d.phase        = P_RESTORE;
					d.cfg          = cfg_of(MODE_RESTORE);
					d.rst.start    = 1'b1;
					d.rst.mark_set = 1'b1;
					d.rst.overdue  = 1'b0;
					d.rst.kind     = RESTORE_KIND;
				end
				else
				begin
					case (q.strap)
						STRAP_SERIAL_LOAD:
						begin
							d.phase    = P_LOAD;
							d.cfg      = cfg_of(MODE_SERIAL_LOAD);
							d.core_run = 1'b1;
						end
						STRAP_TWO_PIN:
						begin
							d.phase    = P_RUN;
							d.cfg      = cfg_of(MODE_TWO_PIN);
							d.core_run = 1'b1;
						end
						STRAP_FOUR_PIN:
						begin
							d.phase    = P_RUN;
							d.cfg      = cfg_of(MODE_FOUR_PIN);
							d.core_run = 1'b1;
						end
						STRAP_BREAK:
						begin
							d.phase    = P_WATCH;
							d.cfg      = cfg_of(MODE_BREAK_WATCH);
							d.core_run = 1'b1;
						end
						STRAP_RESTORE:
						begin
							if (RESTORE_KIND == RESTORE_PARAMS ||
								RESTORE_KIND == RESTORE_IMAGE_PARAMS)
							begin
								d.phase        = P_RESTORE;
								d.cfg          = cfg_of(MODE_RESTORE);
								d.rst.start    = 1'b1;
								d.rst.mark_set = 1'b1;
								d.rst.overdue  = 1'b0;
								d.rst.kind     = RESTORE_KIND;
							end
							else
							begin
								// Nothing selected: plain default boot
								d.phase    = P_RUN;
								d.cfg      = cfg_of(MODE_FOUR_PIN);
								d.core_run = 1'b1;
							end
						end
						default:
						begin
							d.phase = P_RESERVED;
							d.cfg   = cfg_of(MODE_RESERVED);
						end
					endcase
				end
			end
			P_WATCH:
			begin
				d.count     = q.count + COUNT_ONE;
				d.brk_count = rx_s ? COUNT_ZERO : q.brk_count + COUNT_ONE;
				if (break_seen)
				begin
					d.phase = P_LOAD;
					d.cfg   = cfg_of(MODE_SERIAL_LOAD);
				end
				else if (watch_over)
				begin
					d.phase = P_RUN;
					d.cfg   = cfg_of(MODE_FOUR_PIN);
				end
			end
			P_LOAD:
			begin
				// Waits forever; only a strap change or external reset low gets out
				if (strap_s != q.strap)
				begin
					d.strap    = strap_s;
					d.phase    = P_DECIDE;
					d.core_run = 1'b0;
					d.cfg      = cfg_of(MODE_NONE);
				end
			end
			P_RESTORE:
			begin
				// Late restore is flagged but left to finish
				if (q.count != RESTORE_TIMEOUT_CYCLES)
				begin
					d.count = q.count + COUNT_ONE;
				end
				if (q.count == RESTORE_TIMEOUT_CYCLES - COUNT_ONE)
				begin
					d.rst.overdue = 1'b1;
				end
				if (RESTORE_DONE)
				begin
					d.rst.mark_set = 1'b0;
					d.rst.mark_clr = 1'b1;
					d.phase        = P_RUN;
					d.cfg          = cfg_of(MODE_FOUR_PIN);
					d.core_run     = 1'b1;
				end
			end
			P_RUN:
			begin
				d.phase = P_RUN;
			end
			P_RESERVED:
			begin
				d.phase = P_RESERVED;
			end
			default:
			begin
				d.phase = P_WAIT;
			end
		endcase
		// External reset low reboots; the stored marker keeps a restore alive
		if (!ext_s)
		begin
			// A decision cut by reset must not launch a restore
			d.rst.start    = 1'b0;
			d.rst.mark_set = q.rst.mark_set && !d.rst.mark_clr;
			d.phase    = P_WAIT;
			d.core_run = 1'b0;
			d.cfg      = cfg_of(MODE_NONE);
			d.strap    = strap_s;
			d.count    = COUNT_ZERO;
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RESETN)
		begin
			q.phase     <= P_WAIT;
			q.strap     <= STRAP_RESET_VAL;
			q.ext_prev  <= 1'b0;
			q.core_run  <= 1'b0;
			q.cfg       <= '{MODE_NONE, DBG_OFF, UART0_OFF};
			q.rst       <= '{1'b0, 1'b0, 1'b0, 1'b0, RESTORE_NONE};
			q.count     <= COUNT_ZERO;
			q.brk_count <= COUNT_ZERO;
		end
		else
		begin
			q <= d;
		end
	end

	// Restore engine owns the flash; factory sector is never granted
	assign HOST_FLASH_GRANT  = HOST_FLASH_REQ && !HOST_FLASH_IN_FACTORY &&
		(q.phase != P_RESTORE);
	assign STRAP_PULLDOWN_EN = STRAP_PULL_ALL;
	assign BOOT_CFG          = q.cfg;
	assign RESTORE_CTL       = q.rst;
	assign STRAP_LATCHED     = q.strap;
	assign CORE_RUN          = q.core_run;

	sequence s_decide_clean;
		(q.phase == P_DECIDE) && !NV_RESTORE_PENDING && ext_s;
	endsequence

	sequence s_restore_go;
		s_decide_clean and ((q.strap == STRAP_RESTORE) &&
			(RESTORE_KIND == RESTORE_PARAMS || RESTORE_KIND == RESTORE_IMAGE_PARAMS));
	endsequence

	a_strap_latch: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(q.phase == P_WAIT) && ext_rise |=> (q.phase == P_DECIDE) &&
			(q.strap == $past(strap_s)))
		else $error("straps not latched at reset rise");

	a_restore_start: assert property (@(posedge CLOCK) disable iff (!RESETN)
		s_restore_go |=> RESTORE_CTL.start && RESTORE_CTL.mark_set &&
			(q.phase == P_RESTORE) && !CORE_RUN ##1 !RESTORE_CTL.start)
		else $error("restore did not start as a one-cycle pulse");

	a_restore_none: assert property (@(posedge CLOCK) disable iff (!RESETN)
		s_decide_clean and ((q.strap == STRAP_RESTORE) && (RESTORE_KIND == RESTORE_NONE))
			|=> (q.phase == P_RUN) && !RESTORE_CTL.start)
		else $error("restore started with no selection");

	a_restore_resume: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(q.phase == P_DECIDE) && NV_RESTORE_PENDING && ext_s
			|=> (q.phase == P_RESTORE) && RESTORE_CTL.mark_set)
		else $error("pending restore not resumed");

	a_restore_no_abort: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(q.phase == P_RESTORE) && !RESTORE_DONE && ext_s
			|=> (q.phase == P_RESTORE) && !CORE_RUN)
		else $error("restore left without done");

	a_factory_guard: assert property (@(posedge CLOCK) disable iff (!RESETN)
		HOST_FLASH_IN_FACTORY || (q.phase == P_RESTORE) |-> !HOST_FLASH_GRANT)
		else $error("host granted protected flash");

	a_serial_load: assert property (@(posedge CLOCK) disable iff (!RESETN)
		s_decide_clean and (q.strap == STRAP_SERIAL_LOAD) |=> (q.phase == P_LOAD) &&
			(BOOT_CFG.debug == DBG_JTAG4) ##1 ((q.phase == P_LOAD) || !$past(ext_s)
			|| ($past(strap_s) != $past(q.strap))))
		else $error("serial load not entered or left early");

	a_load_holds: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(q.phase == P_LOAD) && (strap_s == q.strap) && ext_s |=> (q.phase == P_LOAD))
		else $error("serial load left without strap change");

	a_two_pin: assert property (@(posedge CLOCK) disable iff (!RESETN)
		s_decide_clean and (q.strap == STRAP_TWO_PIN)
			|=> (BOOT_CFG.mode == MODE_TWO_PIN) && (BOOT_CFG.debug == DBG_SWD2) && CORE_RUN)
		else $error("two-pin debug mode wrong");

	a_four_pin: assert property (@(posedge CLOCK) disable iff (!RESETN)
		s_decide_clean and (q.strap == STRAP_FOUR_PIN)
			|=> (BOOT_CFG.mode == MODE_FOUR_PIN) && (BOOT_CFG.debug == DBG_JTAG4) && CORE_RUN)
		else $error("four-pin debug mode wrong");

	a_break_load: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(q.phase == P_WATCH) && !rx_s && ext_s &&
			(q.brk_count == BREAK_MIN_CYCLES - COUNT_ONE)
			|=> (BOOT_CFG.mode == MODE_SERIAL_LOAD) && (q.phase == P_LOAD))
		else $error("break did not enter serial load");

	a_no_break_run: assert property (@(posedge CLOCK) disable iff (!RESETN)
		(q.phase == P_WATCH) && !break_seen && ext_s && watch_over
			|=> (BOOT_CFG.mode == MODE_FOUR_PIN) && (BOOT_CFG.debug == DBG_JTAG4))
		else $error("watch without break did not run");

	a_reserved_hold: assert property (@(posedge CLOCK) disable iff (!RESETN)
		s_decide_clean and (q.strap[2] && (q.strap[1] || q.strap[0]))
			|=> (q.phase == P_RESERVED) && !CORE_RUN ##1 !CORE_RUN)
		else $error("reserved pattern gained behaviour");

	a_pulldown_on: assert property (@(posedge CLOCK) disable iff (!RESETN)
		STRAP_PULLDOWN_EN == STRAP_PULL_ALL)
		else $error("strap pull-down not enabled");
endmodule // bmsel_top

// *** sim/bmsel_board_model.sv ***
`timescale 1ns/1ps
module bmsel_board_model #(
	parameter int unsigned HOLD_CYC = 6
) (
	input  wire logic       clock,
	input  wire logic [2:0] strap_val,
	input  wire logic [2:0] strap_fit,
	input  wire logic       toggle,
	output logic      [2:0] strap_pins,
	output logic            ext_reset_n,
	output logic            busy
);
	int unsigned hold_q = 0;

	// Unfitted strap floats and reads low; a fitted strap reads back strap_val
	assign strap_pins = strap_val & strap_fit;

	// Straps stay put for the whole low pulse and its rising edge
	always @(negedge clock)
	begin
		if (toggle && hold_q == 0)
			hold_q <= HOLD_CYC;
		else if (hold_q != 0)
			hold_q <= hold_q - 1;
	end

	assign ext_reset_n = (hold_q == 0);
	assign busy        = (hold_q != 0);
endmodule // bmsel_board_model

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
	import bmsel_pkg::*;
	localparam logic [31:0] TMO  = 32'h32;
	localparam logic [31:0] BMIN = 32'h4;
	localparam logic [31:0] BWIN = 32'h28;
	logic              clock     = 1'b0;
	logic              resetn    = 1'b0;
	logic [2:0]        strap_val = 3'h0;
	logic              toggle    = 1'b0;
	logic              uart_rx   = 1'b1;
	logic              pend      = 1'b0;
	bmsel_kind_type    kind      = RESTORE_NONE;
	logic              done      = 1'b0;
	logic              req       = 1'b0;
	logic              fac       = 1'b0;
	logic [31:0]       lfsr      = 32'hD0B15143;
	logic [2:0]        pins;
	logic              ext_n;
	logic              busy;
	logic              grant;
	bmsel_cfg_type     cfg;
	bmsel_restore_type ctl;
	logic [2:0]        latched;
	logic [2:0]        pd_en;
	logic              run;
	int                err_count   = 0;
	int                check_count = 0;
	int                starts      = 0;

	initial
	begin
		forever #4 clock = ~clock;
	end

	bmsel_board_model board_u (
		.clock       (clock),
		.strap_val   (strap_val),
		.strap_fit   (3'h7),
		.toggle      (toggle),
		.strap_pins  (pins),
		.ext_reset_n (ext_n),
		.busy        (busy)
	);

	bmsel_top #(
		.RESTORE_TIMEOUT_CYCLES (TMO),
		.BREAK_MIN_CYCLES       (BMIN),
		.BREAK_WATCH_CYCLES     (BWIN)
	) dut_u (
		.CLOCK                 (clock),
		.RESETN                (resetn),
		.BOOT_STRAP_LINES      (pins),
		.EXT_RESET_IN_N        (ext_n),
		.UART_RX               (uart_rx),
		.NV_RESTORE_PENDING    (pend),
		.RESTORE_KIND          (kind),
		.RESTORE_DONE          (done),
		.HOST_FLASH_REQ        (req),
		.HOST_FLASH_IN_FACTORY (fac),
		.HOST_FLASH_GRANT      (grant),
		.BOOT_CFG              (cfg),
		.RESTORE_CTL           (ctl),
		.STRAP_LATCHED         (latched),
		.STRAP_PULLDOWN_EN     (pd_en),
		.CORE_RUN              (run)
	);

	always @(posedge clock)
	begin
		if (ctl.start === 1'b1)
			starts <= starts + 1;
	end

	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	function automatic bmsel_mode_type exp_mode(input logic [2:0] s, input bmsel_kind_type k,
		input logic p);
		if (p)
			return MODE_RESTORE;
		case (s)
			STRAP_SERIAL_LOAD: return MODE_SERIAL_LOAD;
			STRAP_TWO_PIN:     return MODE_TWO_PIN;
			STRAP_FOUR_PIN:    return MODE_FOUR_PIN;
			STRAP_BREAK:       return MODE_BREAK_WATCH;
			STRAP_RESTORE:     return (k inside {RESTORE_PARAMS, RESTORE_IMAGE_PARAMS}) ?
				MODE_RESTORE : MODE_FOUR_PIN;
			default:           return MODE_RESERVED;
		endcase
	endfunction

	function automatic bmsel_cfg_type exp_cfg(input bmsel_mode_type m);
		case (m)
			MODE_SERIAL_LOAD: return '{m, DBG_JTAG4, UART0_LOADER};
			MODE_TWO_PIN:     return '{m, DBG_SWD2, UART0_APP};
			default:          return '{m, DBG_JTAG4, UART0_APP};
		endcase
	endfunction

	task automatic final_report();
		$display("Checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk1(input string n, input logic e, input logic s);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic chk3(input string n, input logic [2:0] e, input logic [2:0] s);
		check_count++;
		if (s !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic chkc(input bmsel_cfg_type e);
		check_count++;
		if (cfg !== e)
		begin
			err_count++;
			$display("Error boot_cfg expected %h seen %h", e, cfg);
		end
	endtask

	// Random host traffic; grant is combinational so it settles in 1 ns
	task automatic idle(input int n, input logic restoring);
		repeat (n)
		begin
			@(negedge clock);
			lfsr = next_rand(lfsr);
			req  = lfsr[0];
			fac  = lfsr[1];
			#1;
			chk1("grant", req & ~fac & ~restoring, grant);
		end
	endtask

	task automatic wait_mode(input bmsel_mode_type m, input int bound);
		int i;
		for (i = 0; i < bound && cfg.mode !== m; i++)
			@(negedge clock);
		if (cfg.mode !== m)
		begin
			err_count++;
			$display("Error wait_mode expected %h seen %h", m, cfg.mode);
			final_report();
		end
	endtask

	task automatic boot(input logic [2:0] s, input bmsel_kind_type k, input logic p,
		input logic alt);
		bmsel_mode_type m;
		int             s0;
		int             i;
		m = exp_mode(s, k, p);
		@(negedge clock);
		strap_val = s;
		kind      = k;
		pend      = p;
		// Non-blocking so the board model samples it race-free on the next edge
		toggle    <= 1'b1;
		s0        = starts;
		@(negedge clock);
		toggle <= 1'b0;
		@(negedge clock);
		for (i = 0; i < 20 && busy; i++)
			@(negedge clock);
		if (busy)
		begin
			err_count++;
			$display("Error board_busy expected %h seen %h", 1'b0, busy);
			final_report();
		end
		// Decision lands about four cycles after the rising edge
		repeat (6) @(negedge clock);
		idle(4, m == MODE_RESTORE);
		chk3("latched", s, latched);
		chk3("mode", m, cfg.mode);
		if (m inside {MODE_SERIAL_LOAD, MODE_TWO_PIN, MODE_FOUR_PIN})
			chkc(exp_cfg(m));
		if (m != MODE_BREAK_WATCH)
			chk1("run", m inside {MODE_SERIAL_LOAD, MODE_TWO_PIN, MODE_FOUR_PIN}, run);
		if (m == MODE_RESTORE)
		begin
			chk1("start", 1'b1, starts == s0 + 1);
			chk1("overdue", 1'b0, ctl.overdue);
			chk3("kind", {1'b0, k}, {1'b0, ctl.kind});
			chk1("mark_set", 1'b1, ctl.mark_set);
			if (alt)
			begin
				// Slow flash: late flag only, restore keeps going
				idle(int'(TMO) + 10, 1'b1);
				chk1("overdue", 1'b1, ctl.overdue);
				chk3("mode", MODE_RESTORE, cfg.mode);
			end
			@(negedge clock);
			done = 1'b1;
			@(negedge clock);
			done = 1'b0;
			pend = 1'b0;
			chk1("mark_clr", 1'b1, ctl.mark_clr);
			wait_mode(MODE_FOUR_PIN, 10);
			chk1("run", 1'b1, run);
			chk1("mark_set", 1'b0, ctl.mark_set);
		end
		else if (m == MODE_BREAK_WATCH)
		begin
			if (alt)
			begin
				uart_rx = 1'b0;
				wait_mode(MODE_SERIAL_LOAD, 12);
				uart_rx = 1'b1;
			end
			else
				wait_mode(MODE_FOUR_PIN, 50);
			chkc(exp_cfg(alt ? MODE_SERIAL_LOAD : MODE_FOUR_PIN));
		end
		else if (m == MODE_SERIAL_LOAD || m == MODE_RESERVED)
		begin
			idle(12, 1'b0);
			chk3("mode", m, cfg.mode);
			chk1("run", m == MODE_SERIAL_LOAD, run);
			if (m == MODE_SERIAL_LOAD)
			begin
				strap_val = STRAP_TWO_PIN;
				wait_mode(MODE_TWO_PIN, 12);
				chk3("latched", STRAP_TWO_PIN, latched);
			end
		end
		$display("boot straps %h kind %h pending %h done", s, k, p);
	endtask

	initial
	begin
		repeat (12) @(negedge clock);
		resetn = 1'b1;
		repeat (10) @(negedge clock);
		chk3("pulldown", 3'h7, pd_en);
		chk3("mode", MODE_FOUR_PIN, cfg.mode);
		for (int i = 0; i < 8; i++)
			boot(3'(i), RESTORE_PARAMS, 1'b0, i[0]);
		boot(STRAP_BREAK, RESTORE_NONE, 1'b0, 1'b1);
		boot(STRAP_RESTORE, RESTORE_NONE, 1'b0, 1'b0);
		boot(STRAP_RESTORE, RESTORE_IMAGE_PARAMS, 1'b0, 1'b0);
		boot(STRAP_FOUR_PIN, RESTORE_IMAGE_PARAMS, 1'b1, 1'b0);
		repeat (12)
		begin
			lfsr = next_rand(lfsr);
			boot(lfsr[2:0], bmsel_kind_type'(lfsr[4:3]), 1'b0, lfsr[7]);
		end
		final_report();
	end
endmodule // tb
